// *** bench/hpi_host_model.sv ***
////////////////////////////////////////////////////////////////////////////
// external host processor: drives host pins, reads back resolved lines
module hpi_host_model (
  input wire logic clk,
  input wire logic [hpi_pkg::HD_W-1:0] dev_o,
  input wire logic [hpi_pkg::HD_W-1:0] dev_oe,
  output logic [hpi_pkg::HD_W-1:0] lines,
  output logic [hpi_pkg::ADDR_W-1:0] addr,
  output logic sel_a,
  output logic sel_b,
  output logic dir,
  output logic rd,
  output logic ds,
  output logic wr,
  output logic spol,
  output logic dual,
  output logic narrow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [hpi_pkg::HD_W-1:0] drv_q; // last value the host put out
  logic drv_en; // host drives the data lines
  // no pull on the lines: released lines show the inverse of the last value
  assign lines = (dev_oe & dev_o) |
                 (~dev_oe & (drv_en ? drv_q : ~drv_q));
  initial begin
    {addr, sel_a, sel_b, dir, rd, ds, wr, dual, narrow} = '0;
    spol = 1'b1;
    drv_q = 16'h0000;
    drv_en = 1'b0;
  end
  // strobe scheme, polarity and width; strobes parked at the idle level
  task set_mode(input logic p, input logic d, input logic n);
    @(negedge clk);
    spol = p;
    dual = d;
    narrow = n;
    {rd, ds, wr} = {3{~p}};
    repeat (6) @(negedge clk);
  endtask
  // one host access; a read holds the strobe until the device drives
  task xfer(input logic is_rd, input logic [1:0] sel,
            input logic [hpi_pkg::ADDR_W-1:0] a,
            input logic [hpi_pkg::HD_W-1:0] d,
            output logic [hpi_pkg::HD_W-1:0] q);
    @(negedge clk);
    addr = a;
    {sel_b, sel_a} = sel;
    dir = is_rd;
    drv_q = d;
    drv_en = !is_rd;
    if (!dual) begin
      ds = spol;
    end else if (is_rd) begin
      rd = spol;
    end else begin
      wr = spol;
    end
    q = lines;
    if (is_rd) begin
      for (int i = 0; i < 12 && dev_oe == '0; i++) @(negedge clk);
      q = lines;
    end else begin
      repeat (5) @(negedge clk);
    end
    @(negedge clk);
    {rd, ds, wr} = {3{~spol}};
    {sel_a, sel_b, drv_en} = '0;
    repeat (3) @(negedge clk);
  endtask
endmodule

// *** bench/tb_host_port_pin_interface.sv ***
////////////////////////////////////////////////////////////////////////////
// bench top: host model on the pins, core and system side from here
module tb_host_port_pin_interface;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, en, fullw, rpol, dreq, odr, ack;
  logic [15:0] hd_i, hd_o, hd_oe, wdat, cdat, q;
  logic [3:0] ra, waddr, raddr, caddr, rsv, rsv_c;
  logic sa, sb, dir, rd, ds, wr, spol, dual, nar;
  logic sreq, sreq_oe, treq, treq_oe, rreq, rreq_oe;
  logic cwe, rxp, wval, wrdy, rdone, ovr;
  logic sdrv, low_oe, mid_oe, top_oe, par, par_oe, ext2, ext2_s;
  logic [7:0] sbyte;
  int n_errors, num_checks, cyc;

  hpi_top dut (.clk(clk), .srst(srst), .host_port_en(en),
    .full_width_mode(fullw), .req_polarity_select(rpol),
    .dual_request_select(dreq), .request_open_drain(odr),
    .host_data_lines_i(hd_i), .host_data_lines_o(hd_o),
    .host_data_lines_oe(hd_oe), .host_register_select(ra),
    .host_select_a(sa), .host_select_b(sb), .host_direction(dir),
    .host_read_strobe(rd), .host_single_strobe(ds),
    .host_write_strobe(wr), .host_acknowledge_in(ack),
    .strobe_polarity_select(spol), .dual_strobe_select(dual),
    .narrow_width_select(nar), .host_service_request_o(sreq),
    .host_service_request_oe(sreq_oe), .host_transmit_request_o(treq),
    .host_transmit_request_oe(treq_oe), .host_receive_request_o(rreq),
    .host_receive_request_oe(rreq_oe), .core_reg_we(cwe),
    .core_reg_addr(caddr), .core_reg_data(cdat), .core_rx_pending(rxp),
    .host_wr_valid(wval), .host_wr_ready(wrdy), .host_wr_addr(waddr),
    .host_wr_data(wdat), .host_rd_done(rdone), .host_rd_addr(raddr),
    .write_overrun(ovr), .sys_drive(sdrv), .sys_data_low_byte(sbyte),
    .sys_low_oe(low_oe), .sys_mid_oe(mid_oe), .sys_top_oe(top_oe),
    .byte_lane_parity_low_o(par), .byte_lane_parity_low_oe(par_oe),
    .external_request_two(ext2), .ext_request_two_seen(ext2_s),
    .reserved_pins(rsv), .reserved_pins_core(rsv_c));
  hpi_host_model host (.clk(clk), .dev_o(hd_o), .dev_oe(hd_oe),
    .lines(hd_i), .addr(ra), .sel_a(sa), .sel_b(sb), .dir(dir), .rd(rd),
    .ds(ds), .wr(wr), .spol(spol), .dual(dual), .narrow(nar));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the run needs well under 3000 cycles
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // core loads a host readable register
  task core_wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge clk);
    {cwe, caddr, cdat} = {1'b1, a, d};
    @(negedge clk);
    cwe = 1'b0;
  endtask
  // host read, then the read-done pulse and released lines
  task rd_chk(input logic [1:0] s, input logic [3:0] a,
              input logic [15:0] e, input logic [15:0] m);
    host.xfer(1'b1, s, a, 16'h0000, q);
    chk(q & m, e & m);
    for (int i = 0; i < 12 && !rdone; i++) @(negedge clk);
    chk(rdone, 1'b1);
    chk(raddr, a);
    step(1);
    chk({rdone, hd_oe}, 17'h0_0000);
  endtask
  // core takes one buffered host write
  task pop(input logic [3:0] a, input logic [15:0] d);
    for (int i = 0; i < 12 && !wval; i++) @(negedge clk);
    chk({wval, waddr, wdat}, {1'b1, a, d});
    wrdy = 1'b1;
    step(1);
    wrdy = 1'b0;
    // idle edge so back to back pops never toggle ready in one step
    step(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {srst, en, rpol, dreq} = 4'hf;
    {fullw, odr, ack, cwe, rxp, wrdy, sdrv, ext2} = '0;
    {caddr, cdat, sbyte, rsv, cyc, n_errors, num_checks} = '0;
    step(12);
    chk({hd_oe, sreq_oe, treq_oe, rreq_oe}, 19'h0_0000);
    srst = 1'b0;
    step(6);
    // reads: both selects, both strobe schemes, both widths
    core_wr(4'h3, 16'ha5c3);
    core_wr(4'hc, 16'h3c5a);
    rd_chk(2'b01, 4'h3, 16'ha5c3, 16'hffff);
    host.set_mode(1'b0, 1'b1, 1'b0);
    rd_chk(2'b10, 4'hc, 16'h3c5a, 16'hffff);
    host.set_mode(1'b1, 1'b0, 1'b1);
    rd_chk(2'b11, 4'h3, 16'ha5c3, 16'h00ff);
    host.xfer(1'b1, 2'b00, 4'h3, 16'h0000, q);
    chk({hd_oe, rdone}, 17'h0_0000);
    $display("test reads done");
    // writes fill the buffer while the core stalls
    host.set_mode(1'b1, 1'b0, 1'b0);
    host.xfer(1'b0, 2'b01, 4'h5, 16'h1234, q);
    host.set_mode(1'b0, 1'b1, 1'b0);
    host.xfer(1'b0, 2'b10, 4'h6, 16'hbeef, q);
    host.set_mode(1'b1, 1'b0, 1'b1);
    host.xfer(1'b0, 2'b01, 4'h8, 16'hcafe, q);
    host.xfer(1'b0, 2'b00, 4'h9, 16'h9999, q);
    host.set_mode(1'b1, 1'b0, 1'b0);
    host.xfer(1'b0, 2'b10, 4'h7, 16'h0f0f, q);
    // push lands a few edges after the strobe is seen released
    step(3);
    chk({ovr, treq, treq_oe}, 3'b001);
    host.xfer(1'b0, 2'b01, 4'ha, 16'h5555, q);
    step(3);
    chk(ovr, 1'b1);
    rxp = 1'b1;
    step(3);
    chk({rreq, rreq_oe, sreq_oe}, 3'b110);
    pop(4'h5, 16'h1234);
    pop(4'h6, 16'hbeef);
    pop(4'h8, 16'h00fe);
    pop(4'h7, 16'h0f0f);
    step(12);
    chk({wval, treq, treq_oe}, 3'b011);
    $display("test writes done");
    // request polarity, open drain, single request with acknowledge
    {odr, rpol} = 2'b10;
    step(3);
    chk({rreq, rreq_oe}, 2'b01);
    rxp = 1'b0;
    step(3);
    chk(rreq_oe, 1'b0);
    {odr, rpol, dreq} = 3'b010;
    step(3);
    chk({sreq, sreq_oe, treq_oe}, 3'b110);
    ack = 1'b1;
    step(8);
    chk({sreq, sreq_oe}, 2'b01);
    $display("test requests done");
    // system bus lanes, parity, reserved pins, external request
    {en, fullw, sdrv, rsv} = 7'b011_1010;
    foreach (cdat[i]) begin
      sbyte = 8'h5a ^ 8'(i * 37);
      step(2);
      chk({par, par_oe}, {~^sbyte, 1'b1});
    end
    chk({low_oe, mid_oe, top_oe}, 3'b111);
    chk(rsv_c, 4'ha);
    fullw = 1'b0;
    step(2);
    chk({low_oe, mid_oe, top_oe}, 3'b110);
    en = 1'b1;
    step(8);
    chk({low_oe, mid_oe, top_oe, rsv_c}, 7'b100_0000);
    ext2 = 1'b1;
    step(6);
    chk(ext2_s, 1'b1);
    ext2 = 1'b0;
    step(6);
    chk(ext2_s, 1'b0);
    $display("test system side done");
    tally_and_finish();
  end
endmodule

// *** rtl/hpi_pkg.sv ***
////////////////////////////////////////////////////////////////////////////
// shared widths, pin vector layout and drive patterns for the host port
package hpi_pkg;
  localparam int HD_W = 16;          // host data lines
  localparam int BYTE_W = 8;         // one byte lane
  localparam int ADDR_W = 4;         // host register select lines
  localparam int REG_N = 16;         // host readable registers
  localparam int FIFO_W = ADDR_W + HD_W; // one write entry: addr and data
  localparam int FIFO_D = 4;         // write buffer depth
  localparam int RSV_W = 4;          // dedicated pins reserved in host mode

  // layout of the synchronised pin vector
  localparam int IX_DATA = 0;
  localparam int IX_ADDR = 16;
  localparam int IX_SEL_A = 20;
  localparam int IX_SEL_B = 21;
  localparam int IX_DIR = 22;
  localparam int IX_RD = 23;
  localparam int IX_DS = 24;
  localparam int IX_WR = 25;
  localparam int IX_ACK = 26;
  localparam int IX_SPOL = 27;
  localparam int IX_DUAL = 28;
  localparam int IX_NARROW = 29;
  localparam int IX_EXTBR = 30;
  localparam int IX_RSV = 31;
  localparam int SYNC_W = 35;

  // data line enables for full and narrow reads
  localparam logic [HD_W-1:0] OE_FULL = 16'hffff;
  localparam logic [HD_W-1:0] OE_NARROW = 16'h00ff;
  localparam logic [HD_W-1:0] OE_NONE = 16'h0000;
  localparam logic [HD_W-1:0] HD_ZERO = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [RSV_W-1:0] RSV_ZERO = 4'h0;
  localparam logic [SYNC_W-1:0] SYNC_ZERO = 35'h0_0000_0000;
endpackage

// *** rtl/hpi_top.sv ***
// Summary of operation
// R1: sixteen shared lines driven only during reads
// R2: four select lines pick the internal register
// R3: select is either chip select input active
// R4: single strobe: direction line picks read/write
// R5: dual strobe: separate read and write strobes
// R6: strobe active level is configurable
// R7: strobe polarity input decides strobe level
// R8: dual strobe input chooses strobe scheme
// R9: width input selects 8-bit or 16-bit path
// R10: single request pin with acknowledge, polarity set
// R11: dual mode drives transmit and receive requests
// R12: request pins driven or open drain
// R13: driving agent supplies valid bus data
// R14: top three bits only in full width
// R15: dedicated pins unused while host port enabled
// R16: parity plus low byte holds odd ones
// R17: external master raises second bus request
// R18: host mode keeps lower half 32 bits
// R19: write on strobe trailing edge when selected

////////////////////////////////////////////////////////////////////////////
// shift register fifo: head entry always sits in slot zero
module hpi_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(D);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] CNT_ZERO = CW'(0);

  logic [W-1:0] mem_q [D];   // storage, slot zero is the head
  logic [CW-1:0] cnt_q;      // entries held
  logic [CW-1:0] cnt_d;
  logic valid_q;             // registered not-empty
  logic ready_q;             // registered not-full
  logic push;
  logic pop;

  assign push = in_valid && ready_q;
  assign pop = valid_q && out_ready;
  assign in_ready = ready_q;
  assign out_valid = valid_q;
  assign out_data = mem_q[0];

  // occupancy next value
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + CNT_ONE;
    end else if (pop && !push) begin
      cnt_d = cnt_q - CNT_ONE;
    end
  end

  // flags kept as flops so both sides see clean levels
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= CNT_ZERO;
      valid_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      valid_q <= (cnt_d != CNT_ZERO);
      ready_q <= (cnt_d != CNT_FULL);
    end
  end

  // per slot: shift down on pop, fill the first free slot on push
  for (genvar i = 0; i < D; i++) begin : g_slot
    logic [W-1:0] above;
    if (i < D - 1) begin : g_mid
      assign above = mem_q[i+1];
    end else begin : g_last
      assign above = mem_q[i];
    end
    always_ff @(posedge clk) begin
      if (srst) begin
        mem_q[i] <= '0;
      end else if (pop) begin
        // simultaneous push lands one slot lower
        if (push && (CW'(i) == cnt_q - CNT_ONE)) begin
          mem_q[i] <= in_data;
        end else begin
          mem_q[i] <= above;
        end
      end else if (push && (CW'(i) == cnt_q)) begin
        mem_q[i] <= in_data;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_no_overfill: assert property (cnt_q <= CNT_FULL)
    else $error("fifo count above depth");
endmodule

////////////////////////////////////////////////////////////////////////////
// host port pin logic inside the device
module hpi_top (
  input wire logic clk,
  input wire logic srst,
  // device configuration
  input wire logic host_port_en,
  input wire logic full_width_mode,
  input wire logic req_polarity_select,
  input wire logic dual_request_select,
  input wire logic request_open_drain,
  // host pins
  input wire logic [hpi_pkg::HD_W-1:0] host_data_lines_i,
  output logic [hpi_pkg::HD_W-1:0] host_data_lines_o,
  output logic [hpi_pkg::HD_W-1:0] host_data_lines_oe,
  input wire logic [hpi_pkg::ADDR_W-1:0] host_register_select,
  input wire logic host_select_a,
  input wire logic host_select_b,
  input wire logic host_direction,
  input wire logic host_read_strobe,
  input wire logic host_single_strobe,
  input wire logic host_write_strobe,
  input wire logic host_acknowledge_in,
  input wire logic strobe_polarity_select,
  input wire logic dual_strobe_select,
  input wire logic narrow_width_select,
  output logic host_service_request_o,
  output logic host_service_request_oe,
  output logic host_transmit_request_o,
  output logic host_transmit_request_oe,
  output logic host_receive_request_o,
  output logic host_receive_request_oe,
  // core side
  input wire logic core_reg_we,
  input wire logic [hpi_pkg::ADDR_W-1:0] core_reg_addr,
  input wire logic [hpi_pkg::HD_W-1:0] core_reg_data,
  input wire logic core_rx_pending,
  output logic host_wr_valid,
  input wire logic host_wr_ready,
  output logic [hpi_pkg::ADDR_W-1:0] host_wr_addr,
  output logic [hpi_pkg::HD_W-1:0] host_wr_data,
  output logic host_rd_done,
  output logic [hpi_pkg::ADDR_W-1:0] host_rd_addr,
  output logic write_overrun,
  // system bus side
  input wire logic sys_drive,
  input wire logic [hpi_pkg::BYTE_W-1:0] sys_data_low_byte,
  output logic sys_low_oe,
  output logic sys_mid_oe,
  output logic sys_top_oe,
  output logic byte_lane_parity_low_o,
  output logic byte_lane_parity_low_oe,
  input wire logic external_request_two,
  output logic ext_request_two_seen,
  input wire logic [hpi_pkg::RSV_W-1:0] reserved_pins,
  output logic [hpi_pkg::RSV_W-1:0] reserved_pins_core
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchroniser and agreement filter
  logic [hpi_pkg::SYNC_W-1:0] pin_vec;   // raw pins, packed
  logic [hpi_pkg::SYNC_W-1:0] s1_q;      // first stage, read by s2 only
  logic [hpi_pkg::SYNC_W-1:0] s2_q;
  logic [hpi_pkg::SYNC_W-1:0] s3_q;
  logic [hpi_pkg::SYNC_W-1:0] flt_q;     // accepted pin levels

  assign pin_vec = {reserved_pins, external_request_two,
                    narrow_width_select, dual_strobe_select,
                    strobe_polarity_select, host_acknowledge_in,
                    host_write_strobe, host_single_strobe,
                    host_read_strobe, host_direction, host_select_b,
                    host_select_a, host_register_select,
                    host_data_lines_i};

  // three stages; a bit moves only when stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= hpi_pkg::SYNC_ZERO;
      s2_q <= hpi_pkg::SYNC_ZERO;
      s3_q <= hpi_pkg::SYNC_ZERO;
      flt_q <= hpi_pkg::SYNC_ZERO;
    end else begin
      s1_q <= pin_vec;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strobe decode
  logic spol;        // 1: strobes active high
  logic dual;        // separate read and write strobes
  logic narrow;      // 8-bit data path
  logic sel;         // effective chip select
  logic rd_act;      // read strobe active and enabled
  logic wr_act;      // write strobe active and enabled
  logic ds_on;
  logic [hpi_pkg::ADDR_W-1:0] addr;
  logic [hpi_pkg::HD_W-1:0] din;

  assign spol = flt_q[hpi_pkg::IX_SPOL];                     // R7
  assign dual = flt_q[hpi_pkg::IX_DUAL];                     // R8
  assign narrow = flt_q[hpi_pkg::IX_NARROW];                 // R9
  assign sel = flt_q[hpi_pkg::IX_SEL_A] | flt_q[hpi_pkg::IX_SEL_B]; // R3
  assign addr = flt_q[hpi_pkg::IX_ADDR +: hpi_pkg::ADDR_W];  // R2
  assign din = flt_q[hpi_pkg::IX_DATA +: hpi_pkg::HD_W];
  assign ds_on = ~(flt_q[hpi_pkg::IX_DS] ^ spol);            // R6

  // pick strobe scheme; all strobes dead while the port is off
  always_comb begin
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (!host_port_en) begin
      rd_act = 1'b0;
    end else if (dual) begin
      rd_act = ~(flt_q[hpi_pkg::IX_RD] ^ spol);   // R5
      wr_act = ~(flt_q[hpi_pkg::IX_WR] ^ spol);   // R5
    end else begin
      rd_act = ds_on & flt_q[hpi_pkg::IX_DIR];    // R4
      wr_act = ds_on & ~flt_q[hpi_pkg::IX_DIR];   // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write capture: latch while active, commit at trailing edge
  logic rd_act_q;
  logic wr_act_q;
  logic sel_q;
  logic [hpi_pkg::ADDR_W-1:0] wr_addr_q;
  logic [hpi_pkg::HD_W-1:0] wr_data_q;
  logic push;
  logic fifo_ready;
  logic [hpi_pkg::FIFO_W-1:0] fifo_out;

  // strobe history for edge detection
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      sel_q <= sel;
    end
  end

  // data keeps following the lines while the strobe is active, so the
  // value in hand at the trailing edge is the last settled one
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_addr_q <= '0;
      wr_data_q <= hpi_pkg::HD_ZERO;
    end else if (wr_act && sel) begin
      wr_addr_q <= addr;                                     // R2
      if (narrow) begin
        wr_data_q <= {hpi_pkg::BYTE_ZERO,
                      din[hpi_pkg::BYTE_W-1:0]};             // R9
      end else begin
        wr_data_q <= din;
      end
    end
  end

  assign push = wr_act_q && !wr_act && sel_q;                // R19

  // full buffer drops the write; flagged so software can see it
  always_ff @(posedge clk) begin
    if (srst) begin
      write_overrun <= 1'b0;
    end else if (push && !fifo_ready) begin
      write_overrun <= 1'b1;
    end
  end

  hpi_fifo #(
    .W(hpi_pkg::FIFO_W),
    .D(hpi_pkg::FIFO_D)
  ) u_wr_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data({wr_addr_q, wr_data_q}),
    .out_valid(host_wr_valid),
    .out_ready(host_wr_ready),
    .out_data(fifo_out)
  );

  assign host_wr_addr = fifo_out[hpi_pkg::FIFO_W-1:hpi_pkg::HD_W];
  assign host_wr_data = fifo_out[hpi_pkg::HD_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // read side: core loads registers, host reads them
  logic [hpi_pkg::HD_W-1:0] regs_q [hpi_pkg::REG_N];

  // core write port into the host readable registers
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < hpi_pkg::REG_N; i++) begin
        regs_q[i] <= hpi_pkg::HD_ZERO;
      end
    end else if (core_reg_we) begin
      regs_q[core_reg_addr] <= core_reg_data;
    end
  end

  // lines driven only for a selected read; narrow drives low lane only
  always_ff @(posedge clk) begin
    if (srst) begin
      host_data_lines_o <= hpi_pkg::HD_ZERO;
      host_data_lines_oe <= hpi_pkg::OE_NONE;
    end else if (rd_act && sel) begin                        // R1
      host_data_lines_o <= regs_q[addr];                     // R2
      host_data_lines_oe <= narrow ? hpi_pkg::OE_NARROW :
                                     hpi_pkg::OE_FULL;       // R9
    end else begin
      host_data_lines_o <= hpi_pkg::HD_ZERO;
      host_data_lines_oe <= hpi_pkg::OE_NONE;
    end
  end

  // one pulse at the end of each selected read
  always_ff @(posedge clk) begin
    if (srst) begin
      host_rd_done <= 1'b0;
      host_rd_addr <= '0;
    end else begin
      host_rd_done <= rd_act_q && !rd_act && sel_q;
      if (rd_act && sel) begin
        host_rd_addr <= addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request pins
  logic ack_act;     // acknowledge at its configured level
  logic tx_want;     // room in the write buffer
  logic single_want;

  assign ack_act = ~(flt_q[hpi_pkg::IX_ACK] ^ req_polarity_select); // R10
  assign tx_want = fifo_ready;
  // acknowledge holds the single request off while the host answers
  assign single_want = (tx_want | core_rx_pending) & ~ack_act;  // R10

  // level to {output, enable}; open drain only ever pulls low
  function automatic logic [1:0] pin_drive(input logic want,
                                           input logic on);
    logic lvl;
    lvl = ~(want ^ req_polarity_select);                     // R10
    if (!on) begin
      pin_drive = 2'b00;
    end else if (request_open_drain) begin
      pin_drive = {1'b0, ~lvl};                              // R12
    end else begin
      pin_drive = {lvl, 1'b1};                               // R12
    end
  endfunction

  // one scheme active at a time; the other pins float
  always_ff @(posedge clk) begin
    if (srst) begin
      {host_service_request_o, host_service_request_oe} <= 2'b00;
      {host_transmit_request_o, host_transmit_request_oe} <= 2'b00;
      {host_receive_request_o, host_receive_request_oe} <= 2'b00;
    end else begin
      {host_service_request_o, host_service_request_oe} <=
        pin_drive(single_want, host_port_en && !dual_request_select);
      {host_transmit_request_o, host_transmit_request_oe} <=
        pin_drive(tx_want, host_port_en && dual_request_select);  // R11
      {host_receive_request_o, host_receive_request_oe} <=
        pin_drive(core_rx_pending,
                  host_port_en && dual_request_select);      // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system bus lane enables, parity and shared pins
  // lanes driven only when this device owns the bus transfer
  always_ff @(posedge clk) begin
    if (srst) begin
      sys_low_oe <= 1'b0;
      sys_mid_oe <= 1'b0;
      sys_top_oe <= 1'b0;
    end else begin
      sys_low_oe <= sys_drive;                               // R13
      sys_mid_oe <= sys_drive && !host_port_en;              // R18
      sys_top_oe <= sys_drive && full_width_mode && !host_port_en; // R14
    end
  end

  // odd parity over the low byte lane, with the lane's driver
  always_ff @(posedge clk) begin
    if (srst) begin
      byte_lane_parity_low_o <= 1'b0;
      byte_lane_parity_low_oe <= 1'b0;
    end else begin
      byte_lane_parity_low_o <= ~(^sys_data_low_byte);      // R16
      byte_lane_parity_low_oe <= sys_drive;                  // R16
    end
  end

  // request from the second external master goes to the arbiter;
  // dedicated pins are masked off while the host port owns them
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_request_two_seen <= 1'b0;
      reserved_pins_core <= hpi_pkg::RSV_ZERO;
    end else begin
      ext_request_two_seen <= flt_q[hpi_pkg::IX_EXTBR];      // R17
      reserved_pins_core <= host_port_en ? hpi_pkg::RSV_ZERO :
        flt_q[hpi_pkg::IX_RSV +: hpi_pkg::RSV_W];            // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_sel_write;
    (wr_act && sel) ##1 !wr_act;
  endsequence

  a_idle_no_drive: assert property (!(rd_act && sel) |=> // R1
    host_data_lines_oe == hpi_pkg::OE_NONE)
    else $error("data lines driven outside a read");
  a_either_select: assert property ((rd_act && !narrow && // R3
    (flt_q[hpi_pkg::IX_SEL_A] ^ flt_q[hpi_pkg::IX_SEL_B])) |=>
    host_data_lines_oe == hpi_pkg::OE_FULL)
    else $error("single chip select did not open a read");
  a_single_dir: assert property ((host_port_en && !dual && sel && // R4
    ds_on && !flt_q[hpi_pkg::IX_DIR]) |=>
    host_data_lines_oe == hpi_pkg::OE_NONE)
    else $error("write direction drove the data lines");
  a_write_commit: assert property (s_sel_write |-> push) // R19
    else $error("trailing write edge did not push");
  a_dual_rd_pol: assert property ((host_port_en && dual && sel && // R6
    !spol && !flt_q[hpi_pkg::IX_RD]) |=>
    host_data_lines_oe != hpi_pkg::OE_NONE)
    else $error("low active read strobe ignored");
  a_narrow_lane: assert property ((rd_act && sel && narrow) |=> // R9
    host_data_lines_oe == hpi_pkg::OE_NARROW)
    else $error("narrow read drove the upper lane");
  a_req_exclusive: assert property ((host_service_request_oe || // R11
    host_service_request_o) |-> !host_transmit_request_oe &&
    !host_receive_request_oe)
    else $error("both request schemes active");
  a_open_drain: assert property (request_open_drain |=> // R12
    !host_transmit_request_o && !host_service_request_o)
    else $error("open drain request drove high");
  a_top_bits: assert property (sys_top_oe |-> // R14
    $past(full_width_mode) && !$past(host_port_en))
    else $error("top data bits driven outside full width");
  a_odd_parity: assert property (byte_lane_parity_low_oe |-> // R16
    (^{byte_lane_parity_low_o, $past(sys_data_low_byte)}))
    else $error("low lane parity not odd");
  a_rsv_masked: assert property (host_port_en |=> // R15
    reserved_pins_core == hpi_pkg::RSV_ZERO)
    else $error("reserved pins leaked in host mode");
endmodule
